// ==== rtl/ahb_reg_slave.sv ====
`timescale 1ns/1ns
module ahb_reg_slave import serial_tx_pkg::*; (
  input wire logic clk,
  input wire logic nrst,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic hready,
  input wire logic [31:0] hwdata,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  output reg_req_t req,
  input wire logic [7:0] rdata
);

  logic pend_q;
  logic pend_wr_q;
  logic pend_ok_q;
  logic [7:0] pend_idx_q;
  logic take;

  // A transfer is taken when selected, active and the bus is ready.
  assign take = hsel && hready && htrans[1];

  // Address phase capture; every taken transfer gets one wait state.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      pend_q <= 1'b0;
      pend_wr_q <= 1'b0;
      pend_ok_q <= 1'b0;
      pend_idx_q <= 8'h00;
    end else begin
      pend_q <= take;
      if (take) begin
        pend_wr_q <= hwrite;
        pend_ok_q <= (haddr[31:10] == 22'h00_0000) && (haddr[1:0] == 2'h0)
          && (hsize == 3'h2);
        pend_idx_q <= haddr[9:2];
      end
    end
  end

  // Data phase request toward the register file; unmapped writes vanish.
  always_comb begin
    req.wr = pend_q && pend_wr_q && pend_ok_q;
    req.idx = pend_idx_q;
    req.wdata = hwdata[7:0];
  end

  // Ready drops for the wait state; read data is registered with it.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      hreadyout <= 1'b1;
      hrdata <= 32'h0000_0000;
      hresp <= 1'b0;
    end else begin
      hresp <= 1'b0;
      hreadyout <= !take;
      if (pend_q && !pend_wr_q) begin
        hrdata <= pend_ok_q ? {24'h00_0000, rdata} : 32'h0000_0000;
      end
    end
  end

endmodule

// ==== rtl/pin_sync.sv ====
`timescale 1ns/1ns
module pin_sync import serial_tx_pkg::*; #(
  parameter int WIDTH = 1
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic [WIDTH-1:0] pin_in,
  output logic [WIDTH-1:0] level
);

  logic [WIDTH-1:0] s1_q;
  logic [WIDTH-1:0] s2_q;
  logic [WIDTH-1:0] s3_q;

  initial begin
    if (WIDTH < 1) begin
      $error("pin_sync needs at least one bit");
    end
  end

  // Three stages; the first stage is read by the second alone.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      s1_q <= '0;
      s2_q <= '0;
      s3_q <= '0;
    end else begin
      s1_q <= pin_in;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  // A bit takes its new level only once the second and third stages agree.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      level <= '0;
    end else begin
      for (int i = 0; i < WIDTH; i++) begin
        if (s2_q[i] == s3_q[i]) begin
          level[i] <= s3_q[i];
        end
      end
    end
  end

endmodule

// ==== rtl/primary_serial_port_tx.sv ====
// What this block does
// R1: Launch edge default, or opposite half later.
// R2: Unused bits drive zero or float.
// R3: LSB full period, or half then float.
// R4: Keeper off, on, one, or 1.5 periods.
// R5: Controller mode may use internal frame sync.
// R6: Controller mode may use internal bit clock.
// R7: TDM controller sync pulse one or two.
// R8: Slot-0 MSB delayed by 0 to 31.
// R9: Zero offset keeps standard MSB position.
// R10: Each channel routed to primary or secondary.
// R11: Offset register upper three bits read zero.
// R12: Transmit registers reset to zero.
// R13: Format codes TDM, I2S, left-justified; 3 reserved.
// R14: Word length 16, 20, 24 or 32.
// R15: Clock polarity standard or inverted, edge follows.
//
// Our own choice: register access over AHB-Lite.
`timescale 1ns/1ns
module primary_serial_port_tx import serial_tx_pkg::*; #(
  parameter int BCLK_HALF_CYCLES = INT_BCLK_HALF_CYCLES
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic hready,
  input wire logic [31:0] hwdata,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic ext_bit_clock,
  input wire logic ext_frame_sync,
  input wire logic [7:0][31:0] chan_data,
  output pin_t primary_data_out,
  output pin_t secondary_data_out,
  output logic bus_keeper_en,
  output pin_t bit_clock_out,
  output pin_t frame_sync_out
);

  initial begin
    if (BCLK_HALF_CYCLES < 1 || BCLK_HALF_CYCLES > 255) begin
      $error("BCLK_HALF_CYCLES must lie in 1 to 255");
    end
  end

  reg_req_t req;
  logic [7:0] rdata;
  logic [7:0] port_format_q;
  logic [7:0] tx_format_ctrl_q;
  logic [TX_OFFSET_BITS-1:0] tx_slot0_msb_offset_q;
  logic [7:0] tx_channel_pin_select_q;
  logic controller_mode_q;

  ahb_reg_slave u_bus (
    .clk(clk),
    .nrst(nrst),
    .hsel(hsel),
    .haddr(haddr),
    .htrans(htrans),
    .hwrite(hwrite),
    .hsize(hsize),
    .hready(hready),
    .hwdata(hwdata),
    .hrdata(hrdata),
    .hreadyout(hreadyout),
    .hresp(hresp),
    .req(req),
    .rdata(rdata)
  );

  // Register file writes; only the low five offset bits are stored.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      port_format_q <= RST_PORT_FORMAT;
      tx_format_ctrl_q <= RST_TX_FORMAT_CTRL; // R12
      tx_slot0_msb_offset_q <= RST_TX_MSB_OFFSET[TX_OFFSET_BITS-1:0]; // R12
      tx_channel_pin_select_q <= RST_TX_CHANNEL_PIN_SELECT; // R12
      controller_mode_q <= RST_PORT_MODE[0];
    end else if (req.wr) begin
      unique case (req.idx)
        IDX_PORT_FORMAT: port_format_q <= req.wdata & 8'hf4;
        IDX_TX_FORMAT_CTRL: tx_format_ctrl_q <= req.wdata;
        IDX_TX_MSB_OFFSET: tx_slot0_msb_offset_q <= req.wdata[TX_OFFSET_BITS-1:0]; // R11
        IDX_TX_CHANNEL_PIN_SELECT: tx_channel_pin_select_q <= req.wdata;
        IDX_PORT_MODE: controller_mode_q <= req.wdata[0];
        default: ;
      endcase
    end
  end

  // Field decode.
  logic [1:0] protocol_format;
  logic [1:0] word_length;
  logic bit_clock_polarity;
  logic tx_launch_edge_invert;
  logic tx_unused_fill_hiz;
  logic tx_lsb_half_period;
  logic [1:0] tx_bus_keeper_mode;
  logic tx_use_internal_frame_sync;
  logic tx_use_internal_bit_clock;
  logic tdm_sync_pulse_width;

  assign protocol_format = port_format_q[POS_PROTOCOL_FORMAT +: 2];
  assign word_length = port_format_q[POS_WORD_LENGTH +: 2];
  assign bit_clock_polarity = port_format_q[POS_BIT_CLOCK_POLARITY];
  assign tx_launch_edge_invert = tx_format_ctrl_q[POS_TX_LAUNCH_EDGE_INVERT];
  assign tx_unused_fill_hiz = tx_format_ctrl_q[POS_TX_UNUSED_FILL_HIZ];
  assign tx_lsb_half_period = tx_format_ctrl_q[POS_TX_LSB_HALF_PERIOD];
  assign tx_bus_keeper_mode = tx_format_ctrl_q[POS_TX_BUS_KEEPER_MODE +: 2];
  assign tx_use_internal_frame_sync = tx_format_ctrl_q[POS_TX_USE_INTERNAL_FRAME_SYNC];
  assign tx_use_internal_bit_clock = tx_format_ctrl_q[POS_TX_USE_INTERNAL_BIT_CLOCK];
  assign tdm_sync_pulse_width = tx_format_ctrl_q[POS_TDM_SYNC_PULSE_WIDTH];

  // Last bit index of a word for the selected word length.
  function automatic logic [4:0] word_last(input logic [1:0] code);
    unique case (code)
      2'h0: word_last = 5'h0f;
      2'h1: word_last = 5'h13;
      2'h2: word_last = 5'h17;
      2'h3: word_last = 5'h1f;
    endcase
  endfunction

  logic [4:0] wlast;
  assign wlast = word_last(word_length); // R14

  // Pin inputs pass the three-stage synchroniser.
  logic ext_bclk_f;
  logic ext_fs_f;

  pin_sync #(.WIDTH(2)) u_sync (
    .clk(clk),
    .nrst(nrst),
    .pin_in({ext_bit_clock, ext_frame_sync}),
    .level({ext_bclk_f, ext_fs_f})
  );

  // Internal bit clock divider and frame sync generator for controller mode.
  logic [7:0] div_q;
  logic int_bclk_q;
  logic int_fs_q;
  logic [8:0] int_cnt_q;
  logic [8:0] frame_last;
  logic [8:0] wlen9;
  logic int_fall;

  assign wlen9 = {4'h0, wlast} + 9'h001;
  assign frame_last = (protocol_format == FMT_TDM) ? 9'((wlen9 << 3) - 9'h001)
    : 9'((wlen9 << 1) - 9'h001);
  assign int_fall = int_bclk_q && (div_q == 8'(BCLK_HALF_CYCLES - 1));

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      div_q <= 8'h00;
      int_bclk_q <= 1'b0;
    end else if (!controller_mode_q) begin
      div_q <= 8'h00;
      int_bclk_q <= 1'b0;
    end else if (div_q == 8'(BCLK_HALF_CYCLES - 1)) begin
      div_q <= 8'h00;
      int_bclk_q <= !int_bclk_q;
    end else begin
      div_q <= div_q + 8'h01;
    end
  end

  // Frame counter moves once per internal bit clock period.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      int_cnt_q <= 9'h000;
      int_fs_q <= 1'b0;
    end else if (!controller_mode_q) begin
      int_cnt_q <= 9'h000;
      int_fs_q <= 1'b0;
    end else if (int_fall) begin
      int_cnt_q <= (int_cnt_q >= frame_last) ? 9'h000 : int_cnt_q + 9'h001;
      unique case (protocol_format)
        FMT_TDM: int_fs_q <= (int_cnt_q >= frame_last)
          || (tdm_sync_pulse_width && int_cnt_q == 9'h000); // R7
        FMT_I2S: int_fs_q <= (int_cnt_q + 9'h001 >= wlen9) && (int_cnt_q < frame_last);
        FMT_LEFT_JUSTIFIED: int_fs_q <= (int_cnt_q >= frame_last)
          || (int_cnt_q + 9'h001 < wlen9);
        default: int_fs_q <= 1'b0; // R13
      endcase
    end
  end

  // Clock and sync pins are driven only when the internal source is chosen.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      bit_clock_out <= '0;
      frame_sync_out <= '0;
    end else begin
      bit_clock_out.o <= int_bclk_q ^ bit_clock_polarity;
      bit_clock_out.oe <= controller_mode_q && tx_use_internal_bit_clock;
      frame_sync_out.o <= int_fs_q;
      frame_sync_out.oe <= controller_mode_q && tx_use_internal_frame_sync;
    end
  end

  // Timing source selection and edge finding on the sampled bit clock.
  logic sel_bclk;
  logic sel_fs;
  logic eff_prev_q;
  logic eff_bclk;
  logic rise;
  logic fall;
  logic launch;
  logic opposite;

  assign sel_bclk = (controller_mode_q && tx_use_internal_bit_clock) ? int_bclk_q
    : ext_bclk_f; // R6
  assign sel_fs = (controller_mode_q && tx_use_internal_frame_sync) ? int_fs_q
    : ext_fs_f; // R5
  assign eff_bclk = sel_bclk ^ bit_clock_polarity; // R15
  assign rise = !eff_prev_q && eff_bclk;
  assign fall = eff_prev_q && !eff_bclk;
  assign launch = tx_launch_edge_invert ? rise : fall; // R1
  assign opposite = tx_launch_edge_invert ? fall : rise;

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      eff_prev_q <= 1'b0;
    end else begin
      eff_prev_q <= eff_bclk;
    end
  end

  // Frame sync is sampled on the rising edge of the effective bit clock to find frame and half starts.
  logic fs_prev_q;
  logic start;
  logic start_half;

  always_comb begin
    start = 1'b0;
    start_half = 1'b0;
    if (rise) begin
      unique case (protocol_format)
        FMT_TDM: start = sel_fs && !fs_prev_q;
        FMT_I2S: begin
          start = sel_fs != fs_prev_q;
          start_half = sel_fs;
        end
        FMT_LEFT_JUSTIFIED: begin
          start = sel_fs != fs_prev_q;
          start_half = !sel_fs;
        end
        default: start = 1'b0; // R13
      endcase
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      fs_prev_q <= 1'b0;
    end else if (rise) begin
      fs_prev_q <= sel_fs;
    end
  end

  // Bit position tracking within a frame or half frame.
  logic active_q;
  logic half_q;
  logic [5:0] wait_q;
  logic [4:0] bit_q;
  logic [2:0] slot_q;
  logic [2:0] slot_last;
  logic [2:0] chan;
  logic data_now;
  logic is_lsb;

  assign slot_last = (protocol_format == FMT_TDM) ? 3'h7 : 3'h3;
  assign chan = (protocol_format == FMT_TDM) ? slot_q : {slot_q[1:0], half_q};
  assign data_now = active_q && (wait_q == 6'h00);
  assign is_lsb = bit_q == wlast;

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      active_q <= 1'b0;
      half_q <= 1'b0;
      wait_q <= 6'h00;
      bit_q <= 5'h00;
      slot_q <= 3'h0;
    end else if (start) begin
      active_q <= 1'b1;
      half_q <= start_half;
      wait_q <= {1'b0, tx_slot0_msb_offset_q}
        + ((protocol_format == FMT_I2S) ? 6'h01 : 6'h00); // R8 R9
      bit_q <= 5'h00;
      slot_q <= 3'h0;
    end else if (launch && active_q) begin
      if (wait_q != 6'h00) begin
        wait_q <= wait_q - 6'h01; // R8
      end else if (is_lsb) begin
        bit_q <= 5'h00;
        if (slot_q == slot_last) begin
          active_q <= 1'b0;
        end else begin
          slot_q <= slot_q + 3'h1;
        end
      end else begin
        bit_q <= bit_q + 5'h01;
      end
    end
  end

  // Data pins: channel bit on its selected pin, fill on the other.
  logic to_sec;
  logic data_bit;
  logic lsb_q;
  logic lsb_sec_q;

  assign to_sec = tx_channel_pin_select_q[chan]; // R10
  assign data_bit = chan_data[chan][5'h1f - bit_q];

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      primary_data_out <= '0;
      secondary_data_out <= '0;
      lsb_q <= 1'b0;
      lsb_sec_q <= 1'b0;
    end else if (launch) begin
      primary_data_out.o <= 1'b0;
      primary_data_out.oe <= !tx_unused_fill_hiz; // R2
      secondary_data_out.o <= 1'b0;
      secondary_data_out.oe <= !tx_unused_fill_hiz; // R2
      lsb_q <= data_now && is_lsb;
      lsb_sec_q <= to_sec;
      if (data_now && !start) begin
        if (to_sec) begin
          secondary_data_out.o <= data_bit;
          secondary_data_out.oe <= 1'b1;
        end else begin
          primary_data_out.o <= data_bit;
          primary_data_out.oe <= 1'b1;
        end
      end
    end else if (opposite && lsb_q && tx_lsb_half_period) begin
      if (lsb_sec_q) begin
        secondary_data_out.oe <= 1'b0; // R3
      end else begin
        primary_data_out.oe <= 1'b0; // R3
      end
    end
  end

  // Keeper window counted in half periods from the LSB launch.
  logic [1:0] keep_cnt_q;

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      keep_cnt_q <= 2'h0;
      bus_keeper_en <= 1'b0;
    end else begin
      bus_keeper_en <= (tx_bus_keeper_mode == KEEPER_ON) || (keep_cnt_q != 2'h0); // R4
      if (launch && data_now && is_lsb && !start) begin
        unique case (tx_bus_keeper_mode)
          KEEPER_LSB_ONE: keep_cnt_q <= KEEPER_HALVES_ONE; // R4
          KEEPER_LSB_ONE_HALF: keep_cnt_q <= KEEPER_HALVES_ONE_HALF; // R4
          default: keep_cnt_q <= 2'h0;
        endcase
      end else if ((launch || opposite) && keep_cnt_q != 2'h0) begin
        keep_cnt_q <= keep_cnt_q - 2'h1;
      end
    end
  end

  // Read mux; the offset register shows zeros above its field.
  always_comb begin
    unique case (req.idx)
      IDX_PORT_FORMAT: rdata = port_format_q;
      IDX_TX_FORMAT_CTRL: rdata = tx_format_ctrl_q;
      IDX_TX_MSB_OFFSET: rdata = {3'h0, tx_slot0_msb_offset_q}; // R11
      IDX_TX_CHANNEL_PIN_SELECT: rdata = tx_channel_pin_select_q;
      IDX_PORT_MODE: rdata = {7'h00, controller_mode_q};
      IDX_PORT_STATUS: rdata = {active_q, half_q, slot_q, sel_bclk, sel_fs, data_now};
      default: rdata = 8'h00;
    endcase
  end

endmodule

// ==== rtl/serial_tx_pkg.sv ====
package serial_tx_pkg;

  // Register indices; the byte address on the bus is four times the index.
  localparam logic [7:0] IDX_PORT_FORMAT = 8'h1a;
  localparam logic [7:0] IDX_TX_FORMAT_CTRL = 8'h1b;
  localparam logic [7:0] IDX_TX_MSB_OFFSET = 8'h1c;
  localparam logic [7:0] IDX_TX_CHANNEL_PIN_SELECT = 8'h1d;
  localparam logic [7:0] IDX_PORT_MODE = 8'h30;
  localparam logic [7:0] IDX_PORT_STATUS = 8'h31;

  // Values after reset.
  localparam logic [7:0] RST_PORT_FORMAT = 8'h30;
  localparam logic [7:0] RST_TX_FORMAT_CTRL = 8'h00;
  localparam logic [7:0] RST_TX_MSB_OFFSET = 8'h00;
  localparam logic [7:0] RST_TX_CHANNEL_PIN_SELECT = 8'h00;
  localparam logic [7:0] RST_PORT_MODE = 8'h00;

  // Field positions in the port format register.
  localparam int POS_PROTOCOL_FORMAT = 6;
  localparam int POS_WORD_LENGTH = 4;
  localparam int POS_BIT_CLOCK_POLARITY = 2;

  // Field positions in the transmit format control register.
  localparam int POS_TX_LAUNCH_EDGE_INVERT = 7;
  localparam int POS_TX_UNUSED_FILL_HIZ = 6;
  localparam int POS_TX_LSB_HALF_PERIOD = 5;
  localparam int POS_TX_BUS_KEEPER_MODE = 3;
  localparam int POS_TX_USE_INTERNAL_FRAME_SYNC = 2;
  localparam int POS_TX_USE_INTERNAL_BIT_CLOCK = 1;
  localparam int POS_TDM_SYNC_PULSE_WIDTH = 0;

  // Width of the writable offset field; bits above it read as zero.
  localparam int TX_OFFSET_BITS = 5;

  // Clock cycles per half period of the internally generated bit clock.
  localparam int INT_BCLK_HALF_CYCLES = 4;

  // Stages of the pin input synchroniser.
  localparam int SYNC_STAGES = 3;

  // Protocol formats.
  localparam logic [1:0] FMT_TDM = 2'h0;
  localparam logic [1:0] FMT_I2S = 2'h1;
  localparam logic [1:0] FMT_LEFT_JUSTIFIED = 2'h2;

  // Bus keeper modes.
  localparam logic [1:0] KEEPER_OFF = 2'h0;
  localparam logic [1:0] KEEPER_ON = 2'h1;
  localparam logic [1:0] KEEPER_LSB_ONE = 2'h2;
  localparam logic [1:0] KEEPER_LSB_ONE_HALF = 2'h3;

  // Half-period edge counts that the keeper stays on after an LSB launch.
  localparam logic [1:0] KEEPER_HALVES_ONE = 2'h2;
  localparam logic [1:0] KEEPER_HALVES_ONE_HALF = 2'h3;

  // One pin seen from the design: driven level and output enable.
  typedef struct packed {
    logic o;
    logic oe;
  } pin_t;

  // One register access handed from the bus slave to the register file.
  typedef struct packed {
    logic wr;
    logic [7:0] idx;
    logic [7:0] wdata;
  } reg_req_t;

endpackage

// ==== sim/primary_serial_port_tx_chk.sv ====
`timescale 1ns/1ns
module primary_serial_port_tx_chk import serial_tx_pkg::*; #(
  parameter int BCLK_HALF_CYCLES = INT_BCLK_HALF_CYCLES
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic hready,
  input wire logic [31:0] hrdata,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic ext_bit_clock,
  input wire pin_t primary_data_out,
  input wire pin_t secondary_data_out,
  input wire pin_t bit_clock_out
);
  logic rd_q;
  logic bad_q;
  logic [7:0] idx_q;
  logic bclk_q;
  logic seen_q;
  logic [3:0] quiet_q;
  logic [7:0] half_q;
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);
  // Remembers the kind and place of the transfer now in its data phase.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rd_q <= 1'b0;
      bad_q <= 1'b0;
      idx_q <= 8'h00;
    end else if (hsel && hready && htrans[1]) begin
      rd_q <= !hwrite;
      bad_q <= (haddr[31:10] != 22'h0) || (haddr[1:0] != 2'h0) || (hsize != 3'h2);
      idx_q <= haddr[9:2];
    end
  end
  // Counts cycles since the last bit clock change or bus wait state.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      bclk_q <= 1'b0;
      quiet_q <= 4'h0;
    end else begin
      bclk_q <= ext_bit_clock;
      if (ext_bit_clock != bclk_q || !hreadyout)
        quiet_q <= 4'h0;
      else if (quiet_q != 4'hf)
        quiet_q <= quiet_q + 4'h1;
    end
  end
  // Measures each half period of the driven internal bit clock.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      half_q <= 8'h00;
      seen_q <= 1'b0;
    end else begin
      if (bit_clock_out.o != $past(bit_clock_out.o))
        half_q <= 8'h00;
      else if (half_q != 8'hff)
        half_q <= half_q + 8'h01;
      seen_q <= bit_clock_out.oe && (seen_q || (bit_clock_out.o != $past(bit_clock_out.o)));
    end
  end
  a_resp_okay: assert property (hresp == 1'b0)
    else $error("slave response not okay");
  a_one_wait: assert property (hsel && hready && htrans[1] |=> !hreadyout ##1 hreadyout)
    else $error("transfer did not take exactly one wait state");
  a_rdata_hold: assert property (!$rose(hreadyout) |-> $stable(hrdata))
    else $error("read data moved outside a read completion");
  a_rdata_upper: assert property (hrdata[31:8] == 24'h0)
    else $error("read data upper bits not zero");
  a_offset_high: assert property ($rose(hreadyout) && rd_q && !bad_q &&
    idx_q == IDX_TX_MSB_OFFSET |-> hrdata[7:5] == 3'h0)
    else $error("offset register upper bits not zero");
  a_unmapped_zero: assert property ($rose(hreadyout) && rd_q && bad_q |-> hrdata == 32'h0)
    else $error("unmapped read not zero");
  a_prim_on_edge: assert property ($changed(primary_data_out) && !bit_clock_out.oe
    |-> quiet_q <= 4'h8)
    else $error("primary pin changed away from a bit clock edge");
  a_sec_on_edge: assert property ($changed(secondary_data_out) && !bit_clock_out.oe
    |-> quiet_q <= 4'h8)
    else $error("secondary pin changed away from a bit clock edge");
  a_bclk_half: assert property ($changed(bit_clock_out.o) && bit_clock_out.oe && seen_q |->
    half_q == 8'(BCLK_HALF_CYCLES - 1))
    else $error("internal bit clock half period wrong");
endmodule
bind primary_serial_port_tx primary_serial_port_tx_chk #(.BCLK_HALF_CYCLES(BCLK_HALF_CYCLES))
  primary_serial_port_tx_chk_inst (.clk(clk), .nrst(nrst), .hsel(hsel), .haddr(haddr),
  .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hready(hready), .hrdata(hrdata),
  .hreadyout(hreadyout), .hresp(hresp), .ext_bit_clock(ext_bit_clock),
  .primary_data_out(primary_data_out), .secondary_data_out(secondary_data_out),
  .bit_clock_out(bit_clock_out));

// ==== sim/serial_host_model.sv ====
`timescale 1ns/1ns
module serial_host_model import serial_tx_pkg::*; #(
  parameter int NB = 256
) (
  input wire logic go,
  input wire pin_t prim,
  input wire pin_t sec,
  output logic bclk,
  output logic fsync,
  output logic done,
  output logic [NB-1:0] p_o,
  output logic [NB-1:0] p_oe,
  output logic [NB-1:0] s_o,
  output logic [NB-1:0] s_oe
);
  // The clock stands low between frames, as the host only clocks whole frames.
  initial begin
    bclk = 1'b0;
    fsync = 1'b0;
    done = 1'b0;
  end
  // One TDM frame: a one-period sync pulse, then NB bits captured from both pins.
  // Capture sits late in each bit to allow for the pin sync delay.
  always @(posedge go) begin
    #7;
    fsync = 1'b1;
    #160;
    bclk = 1'b1;
    #160;
    bclk = 1'b0;
    fsync = 1'b0;
    #160;
    bclk = 1'b1;
    for (int i = 0; i < NB; i++) begin
      #160;
      bclk = 1'b0;
      #120;
      p_o[i] = prim.o & prim.oe;
      p_oe[i] = prim.oe;
      s_o[i] = sec.o & sec.oe;
      s_oe[i] = sec.oe;
      #40;
      bclk = 1'b1;
    end
    #160;
    bclk = 1'b0;
    #200;
    done = 1'b1;
    #40;
    done = 1'b0;
  end
endmodule

// ==== sim/tb.sv ====
`timescale 1ns/1ns
module tb import serial_tx_pkg::*;;
  localparam int H = 2;
  logic clk, nrst, hsel, hwrite, go, in_frame, dp_rd;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [31:0] haddr, hwdata, hrdata;
  logic hreadyout, hresp, bus_keeper_en, bclk, fsync, done;
  logic [7:0][31:0] chan_data;
  pin_t prim, sec, bco, fso;
  logic [255:0] p_o, p_oe, s_o, s_oe;
  logic [31:0] rd_q[$], pw_q[$];
  logic [1055:0] fr_q[$];
  int fail_count, check_count, hi_n, lo_n, md, run;
  primary_serial_port_tx #(.BCLK_HALF_CYCLES(H)) primary_serial_port_tx_inst (.clk(clk),
    .nrst(nrst), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
    .hready(hreadyout), .hwdata(hwdata), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .ext_bit_clock(bclk), .ext_frame_sync(fsync), .chan_data(chan_data),
    .primary_data_out(prim), .secondary_data_out(sec), .bus_keeper_en(bus_keeper_en),
    .bit_clock_out(bco), .frame_sync_out(fso));
  serial_host_model serial_host_model_inst (.go(go), .prim(prim), .sec(sec), .bclk(bclk),
    .fsync(fsync), .done(done), .p_o(p_o), .p_oe(p_oe), .s_o(s_o), .s_oe(s_oe));
  task automatic finish_test;
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic cmp32(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      fail_count++;
      $display("wrong value at %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic cmp_frame(input logic [1055:0] got, input logic [1055:0] exp);
    check_count++;
    if (got !== exp) begin
      fail_count++;
      $display("wrong value at %0t got %h expected %h", $time, got, exp);
    end
  endtask
  // One AHB-Lite transfer; a read notes its expected data.
  task automatic bus(input logic wr, input logic [31:0] a, input logic [31:0] d);
    htrans <= 2'h2;
    hwrite <= wr;
    haddr <= a;
    if (!wr)
      rd_q.push_back(d);
    do @(posedge clk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= wr ? d : 32'h0;
    dp_rd <= !wr;
    do @(posedge clk); while (hreadyout !== 1'b1);
    dp_rd <= 1'b0;
  endtask
  function automatic logic [31:0] ad(input logic [7:0] idx);
    return {22'h0, idx, 2'h0};
  endfunction
  // Expected pin levels of both pins per bit, then the keeper figure.
  function automatic logic [1055:0] exp_frame(input logic [7:0] ctl, off, sel, input int wl);
    logic [255:0] po, pe, so, se;
    logic o, e, in, s;
    int pos, k, lsbs;
    lsbs = 0;
    for (int p = 0; p < 256; p++) begin
      pos = p - int'(off);
      k = pos / wl;
      in = pos >= 0 && k < 8;
      o = in ? chan_data[k][31 - pos % wl] : 1'b0;
      e = in ? !(ctl[5] && pos % wl == wl - 1) : !ctl[6];
      o = o & e;
      if (in && pos % wl == wl - 1)
        lsbs++;
      s = in && sel[k];
      po[p] = s ? 1'b0 : o;
      pe[p] = s ? !ctl[6] : e;
      so[p] = s ? o : 1'b0;
      se[p] = s ? e : !ctl[6];
    end
    return {po, pe, so, se,
      32'((ctl[4:3] == 2'h2) ? lsbs * 8 : (ctl[4:3] == 2'h3) ? lsbs * 12 : 0)};
  endfunction
  // Programs the port and runs one host frame on random data.
  task automatic frame(input logic [7:0] fmt, ctl, off, sel);
    bus(1'b1, ad(IDX_PORT_FORMAT), 32'(fmt));
    bus(1'b1, ad(IDX_TX_FORMAT_CTRL), 32'(ctl));
    bus(1'b1, ad(IDX_TX_MSB_OFFSET), 32'(off));
    bus(1'b1, ad(IDX_TX_CHANNEL_PIN_SELECT), 32'(sel));
    for (int k = 0; k < 8; k++)
      chan_data[k] <= $urandom;
    @(posedge clk);
    md = int'(ctl[4:3]);
    hi_n = 0;
    lo_n = 0;
    fr_q.push_back(exp_frame(ctl, off, sel, fmt[5:4] == 2'h3 ? 32 : 16 + 4 * fmt[5:4]));
    go <= 1'b1;
    in_frame <= 1'b1;
    @(posedge done);
    @(posedge clk);
    go <= 1'b0;
    in_frame <= 1'b0;
    $display("frame test ended");
  endtask
  // Checks each result against the oldest note.
  always @(posedge clk) begin
    if (dp_rd && hreadyout === 1'b1)
      cmp32(hrdata, rd_q.pop_front());
    if (in_frame && bus_keeper_en === 1'b1)
      hi_n++;
    else if (in_frame)
      lo_n++;
    if (fso.o === 1'b1)
      run++;
    else begin
      if (run > 0 && pw_q.size() > 0)
        cmp32(32'(run), pw_q.pop_front());
      run = 0;
    end
  end
  always @(posedge done)
    cmp_frame({p_o, p_oe, s_o, s_oe, 32'(md == 1 ? lo_n : hi_n)}, fr_q.pop_front());
  // The clock.
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  // Cuts a hang short.
  initial begin
    #2_000_000;
    fail_count++;
    finish_test;
  end
  // The main sequence.
  initial begin
    {nrst, hwrite, go, in_frame, dp_rd, htrans, haddr, hwdata, chan_data} = '0;
    hsel = 1'b1;
    hsize = 3'h2;
    void'($urandom(61));
    repeat (2) @(posedge clk);
    nrst <= 1'b1;
    @(posedge clk);
    bus(1'b0, ad(IDX_PORT_FORMAT), 32'h0000_0030);
    bus(1'b0, ad(IDX_TX_FORMAT_CTRL), 32'h0000_0000);
    bus(1'b0, ad(IDX_TX_MSB_OFFSET), 32'h0000_0000);
    bus(1'b0, ad(IDX_TX_CHANNEL_PIN_SELECT), 32'h0000_0000);
    bus(1'b0, 32'h0000_0400, 32'h0000_0000);
    bus(1'b1, ad(IDX_TX_MSB_OFFSET), 32'h0000_00ff);
    bus(1'b0, ad(IDX_TX_MSB_OFFSET), 32'h0000_001f);
    $display("register test ended");
    frame(8'h30, 8'h00, 8'h00, 8'h00);
    frame(8'h30, 8'h68, 8'h05, 8'ha5);
    frame(8'h00, 8'h10, 8'h00, 8'($urandom));
    frame(8'h30, 8'h18, 8'h1f, 8'h5a);
    frame(8'h30, 8'h90, 8'h00, 8'h0f);
    bus(1'b1, ad(IDX_PORT_MODE), 32'h0000_0001);
    for (int w = 0; w < 2; w++) begin
      bus(1'b1, ad(IDX_TX_FORMAT_CTRL), 32'(8'h06 | w));
      while (fso.o === 1'b1) @(posedge clk);
      @(posedge clk);
      pw_q.push_back(32'(2 * H * (w + 1)));
      while (pw_q.size() > 0) @(posedge clk);
    end
    $display("sync pulse test ended");
    finish_test;
  end
endmodule
